// ==== core/cpg_params.svh ====
// Register map, field positions and defaults of the complementary generator shutdown block
`ifndef CPG_PARAMS_SVH
`define CPG_PARAMS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define CPG_OFS_CTRL 8'h00
`define CPG_OFS_RSIM 8'h04
`define CPG_OFS_RIS 8'h08
`define CPG_OFS_ASD0 8'h0C
`define CPG_OFS_ASD1 8'h10
`define CPG_OFS_DBR 8'h14
`define CPG_OFS_DBF 8'h18
`define CPG_OFS_ISTAT 8'h1C
`define CPG_OFS_IMASK 8'h20
`define CPG_OFS_STAT 8'h24

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CPG_CTRL_RDBS 2
`define CPG_CTRL_FDBS 3
`define CPG_CTRL_POL_LO 4
`define CPG_CTRL_POL_HI 7
`define CPG_ASD0_FORCE 7
`define CPG_ASD0_AUTO 6
`define CPG_ASD0_BD_HI 5
`define CPG_ASD0_BD_LO 4
`define CPG_ASD0_AC_HI 3
`define CPG_ASD0_AC_LO 2
`define CPG_SRC0_BIT 0
`define CPG_SEL_HI 3
`define CPG_DB_HI 5
`define CPG_INT_SHUT 0
`define CPG_INT_RESUME 1
`define CPG_INT_HI 1

// ------------------------------------------------------------
// Defaults
// ------------------------------------------------------------
`define CPG_CHAIN_DIV 4
`define CPG_DB_WIDTH 6

`endif

// ==== core/cpg_pkg.sv ====
// Types shared by the complementary generator shutdown block
package cpg_pkg;
	// Override level choice for one output pair
	typedef enum logic [1:0] {
		OVR_INACT,
		OVR_LOW,
		OVR_HIGH,
		OVR_TRI
	} cpg_ovr_type;
	typedef logic [31:0] cpg_word_type;
endpackage

// ==== core/cpg_deadband.sv ====
// Dead-band delay counter: fires one pulse the programmed count plus one ticks after a start
`timescale 1ns/10ps
`default_nettype none
module cpg_deadband #(
	parameter int CW = 6
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic start,
	input wire logic abort,
	input wire logic [CW-1:0] count,
	input wire logic use_chain,
	input wire logic chain_tick,
	output logic done
);
	logic [CW-1:0] cnt_ff;
	logic busy_ff;
	logic done_ff;
	wire tick = use_chain ? chain_tick : 1'b1;
	wire at_zero = (cnt_ff == '0);

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	// Load on start, count down on each tick, pulse when expired
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff <= '0;
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (abort) begin
				busy_ff <= 1'b0;
			end else if (start) begin
				cnt_ff <= count;
				busy_ff <= 1'b1;
			end else if (busy_ff && tick) begin
				if (at_zero) begin
					busy_ff <= 1'b0;
					done_ff <= 1'b1;
				end else begin
					cnt_ff <= cnt_ff - 1'b1;
				end
			end
		end
	end

	assign done = done_ff;
endmodule // cpg_deadband
`default_nettype wire

// ==== core/cpg_top.sv ====
// Complementary generator shutdown, restart and dead-band logic with APB registers
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/10ps
`include "cpg_params.svh"
`default_nettype none
module cpg_top #(
	parameter int CHAIN_DIV = `CPG_CHAIN_DIV,
	parameter int DBW = `CPG_DB_WIDTH
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic pin_in,
	input wire logic comparator1_result,
	input wire logic comparator2_result,
	input wire logic logic_cell2_result,
	input wire logic fall_event_in,
	output logic output_a,
	output logic output_a_oe,
	output logic output_b,
	output logic output_b_oe,
	output logic output_c,
	output logic output_c_oe,
	output logic output_d,
	output logic output_d_oe,
	output logic irq
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	logic pready_ff;
	logic pslverr_ff;
	cpg_pkg::cpg_word_type prdata_ff;
	logic rdbs_ff;
	logic fdbs_ff;
	logic [3:0] pol_ff;
	logic rising_source0_mode_ff;
	logic rising_source0_enable_ff;
	logic shutdown_force_bit_ff;
	logic auto_restart_enable_ff;
	logic [1:0] override_level_pair_ac_ff;
	logic [1:0] override_level_pair_bd_ff;
	logic [3:0] sel_ff;
	logic [DBW-1:0] rising_deadband_field_ff;
	logic [DBW-1:0] falling_deadband_field_ff;
	logic [`CPG_INT_HI:0] istat_ff;
	logic [`CPG_INT_HI:0] imask_ff;
	logic irq_ff;
	logic shut_ff;
	logic pin_q_ff;
	logic pwm_ff;
	logic prim_ff;
	logic comp_ff;
	logic [3:0] out_ff;
	logic [3:0] oe_ff;
	logic [7:0] div_ff;
	logic chain_tick_ff;
	logic rise_done;
	logic fall_done;
	logic [3:0] nxt_out;
	logic [3:0] nxt_oe;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	// Answer comes in the second access cycle; writes land on that edge
	wire acc = psel && penable;
	wire nxt_pready = acc && !pready_ff;
	wire wr_en = acc && pready_ff && pwrite;
	wire hit_ctrl = (paddr == `CPG_OFS_CTRL);
	wire hit_rsim = (paddr == `CPG_OFS_RSIM);
	wire hit_ris = (paddr == `CPG_OFS_RIS);
	wire hit_asd0 = (paddr == `CPG_OFS_ASD0);
	wire hit_asd1 = (paddr == `CPG_OFS_ASD1);
	wire hit_dbr = (paddr == `CPG_OFS_DBR);
	wire hit_dbf = (paddr == `CPG_OFS_DBF);
	wire hit_istat = (paddr == `CPG_OFS_ISTAT);
	wire hit_imask = (paddr == `CPG_OFS_IMASK);
	wire hit_stat = (paddr == `CPG_OFS_STAT);
	wire mapped = hit_ctrl | hit_rsim | hit_ris | hit_asd0 | hit_asd1 | hit_dbr | hit_dbf
		| hit_istat | hit_imask | hit_stat;
	wire wr_asd0 = wr_en && hit_asd0;

	// Read data assembly, unused bits read zero
	wire [31:0] rd_ctrl = {24'h000000, pol_ff, fdbs_ff, rdbs_ff, 2'h0};
	wire [31:0] rd_asd0 = {24'h000000, shutdown_force_bit_ff, auto_restart_enable_ff,
		override_level_pair_bd_ff, override_level_pair_ac_ff, 2'h0};
	wire [31:0] rd_dbr = {26'h0000000, rising_deadband_field_ff};
	wire [31:0] rd_dbf = {26'h0000000, falling_deadband_field_ff};
	wire [31:0] rd_stat = {29'h00000000, comp_ff, prim_ff, shut_ff};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl :
		hit_rsim ? {31'h00000000, rising_source0_mode_ff} :
		hit_ris ? {31'h00000000, rising_source0_enable_ff} :
		hit_asd0 ? rd_asd0 :
		hit_asd1 ? {28'h0000000, sel_ff} :
		hit_dbr ? rd_dbr :
		hit_dbf ? rd_dbf :
		hit_istat ? {30'h00000000, istat_ff} :
		hit_imask ? {30'h00000000, imask_ff} :
		hit_stat ? rd_stat : 32'h00000000;

	// Bus answer registers
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h00000000;
		end else begin
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pready && !mapped;
			prdata_ff <= (nxt_pready && !pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Plain control fields written by software
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdbs_ff <= 1'b0;
			fdbs_ff <= 1'b0;
			pol_ff <= 4'h0;
			rising_source0_mode_ff <= 1'b0;
			rising_source0_enable_ff <= 1'b0;
			auto_restart_enable_ff <= 1'b0;
			override_level_pair_ac_ff <= 2'h0;
			override_level_pair_bd_ff <= 2'h0;
			sel_ff <= 4'h0;
			imask_ff <= '0;
		end else if (wr_en) begin
			if (hit_ctrl) begin
				rdbs_ff <= pwdata[`CPG_CTRL_RDBS];
				fdbs_ff <= pwdata[`CPG_CTRL_FDBS];
				pol_ff <= pwdata[`CPG_CTRL_POL_HI:`CPG_CTRL_POL_LO];
			end
			if (hit_rsim)
				rising_source0_mode_ff <= pwdata[`CPG_SRC0_BIT];
			if (hit_ris)
				rising_source0_enable_ff <= pwdata[`CPG_SRC0_BIT];
			if (hit_asd0) begin
				auto_restart_enable_ff <= pwdata[`CPG_ASD0_AUTO];
				override_level_pair_ac_ff <= pwdata[`CPG_ASD0_AC_HI:`CPG_ASD0_AC_LO];
				override_level_pair_bd_ff <= pwdata[`CPG_ASD0_BD_HI:`CPG_ASD0_BD_LO];
			end
			if (hit_asd1)
				sel_ff <= pwdata[`CPG_SEL_HI:0];
			if (hit_imask)
				imask_ff <= pwdata[`CPG_INT_HI:0];
		end
	end

	// Dead-band counts keep their value across resets
	always_ff @(posedge ref_clk) begin
		if (wr_en && hit_dbr)
			rising_deadband_field_ff <= pwdata[`CPG_DB_HI:0];
		if (wr_en && hit_dbf)
			falling_deadband_field_ff <= pwdata[`CPG_DB_HI:0];
	end

	// ------------------------------------------------------------
	// Shutdown control
	// ------------------------------------------------------------
	// Selected sources assert while low
	wire [3:0] src_low = ~{logic_cell2_result, comparator2_result, comparator1_result, pin_in};
	wire src_active = |(sel_ff & src_low);
	wire force_set = (wr_asd0 && pwdata[`CPG_ASD0_FORCE]) || src_active;
	wire force_clr = (wr_asd0 && !pwdata[`CPG_ASD0_FORCE])
		|| auto_restart_enable_ff;
	wire nxt_force = force_set || (shutdown_force_bit_ff && !force_clr);
	wire shut_now = shutdown_force_bit_ff || src_active || shut_ff;

	// Rising event source 0
	wire pin_rise = pin_in && !pin_q_ff;
	wire rise_evt = rising_source0_enable_ff
		&& (rising_source0_mode_ff ? pin_rise : pin_in);
	wire nxt_shut = shutdown_force_bit_ff || src_active || (shut_ff && !rise_evt);

	// Force bit and merged shutdown state
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			shutdown_force_bit_ff <= 1'b0;
			shut_ff <= 1'b0;
			pin_q_ff <= 1'b1; // Idle pin level, so no false edge after reset
		end else begin
			shutdown_force_bit_ff <= nxt_force;
			shut_ff <= nxt_shut;
			pin_q_ff <= pin_in;
		end
	end

	// ------------------------------------------------------------
	// Delay chain tick and dead-band counters
	// ------------------------------------------------------------
	// Divider stands in for the delay chain element period
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			div_ff <= 8'h00;
			chain_tick_ff <= 1'b0;
		end else if (div_ff == 8'(CHAIN_DIV - 1)) begin
			div_ff <= 8'h00;
			chain_tick_ff <= 1'b1;
		end else begin
			div_ff <= div_ff + 8'h01;
			chain_tick_ff <= 1'b0;
		end
	end

	cpg_deadband #(.CW(DBW)) u_rise_db (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.start(rise_evt),
		.abort(shut_now || fall_event_in),
		.count(rising_deadband_field_ff),
		.use_chain(rdbs_ff),
		.chain_tick(chain_tick_ff),
		.done(rise_done)
	);

	cpg_deadband #(.CW(DBW)) u_fall_db (
		.ref_clk(ref_clk),
		.sys_rst(sys_rst),
		.start(fall_event_in),
		.abort(shut_now || rise_evt),
		.count(falling_deadband_field_ff),
		.use_chain(fdbs_ff),
		.chain_tick(chain_tick_ff),
		.done(fall_done)
	);

	// ------------------------------------------------------------
	// Output drive latches
	// ------------------------------------------------------------
	// Primary rises after rising dead-band, complement after falling dead-band
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pwm_ff <= 1'b0;
			prim_ff <= 1'b0;
			comp_ff <= 1'b0;
		end else if (shut_now) begin
			pwm_ff <= 1'b0;
			prim_ff <= 1'b0;
			comp_ff <= 1'b0;
		end else if (rise_evt) begin
			pwm_ff <= 1'b1;
			comp_ff <= 1'b0;
		end else if (fall_event_in) begin
			pwm_ff <= 1'b0;
			prim_ff <= 1'b0;
		end else begin
			if (rise_done && pwm_ff)
				prim_ff <= 1'b1;
			if (fall_done && !pwm_ff)
				comp_ff <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Override multiplexer
	// ------------------------------------------------------------
	// Even outputs follow the primary, odd ones the complement
	for (genvar i = 0; i < 4; i++) begin : g_out
		wire [1:0] ovr = (i % 2 == 0) ? override_level_pair_ac_ff : override_level_pair_bd_ff;
		wire norm = ((i % 2 == 0) ? prim_ff : comp_ff) ^ pol_ff[i];
		wire inact = ((i % 2 == 0) ? 1'b0 : 1'b1) ^ pol_ff[i];
		wire is_low = (ovr == cpg_pkg::OVR_LOW);
		wire is_high = (ovr == cpg_pkg::OVR_HIGH);
		wire is_tri = (ovr == cpg_pkg::OVR_TRI);
		assign nxt_out[i] = !shut_now ? norm :
			is_high ? 1'b1 :
			(is_low || is_tri) ? 1'b0 : inact;
		assign nxt_oe[i] = !(shut_now && is_tri);
	end

	// Registered pin drive
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			out_ff <= 4'h0;
			oe_ff <= 4'h0;
		end else begin
			out_ff <= nxt_out;
			oe_ff <= nxt_oe;
		end
	end

	// ------------------------------------------------------------
	// Interrupts
	// ------------------------------------------------------------
	// Sticky events, write one to clear, a new event wins
	wire [`CPG_INT_HI:0] evt = {shut_ff && !nxt_shut, nxt_shut && !shut_ff};
	wire [`CPG_INT_HI:0] iclr = (wr_en && hit_istat) ? pwdata[`CPG_INT_HI:0] : '0;
	always_ff @(posedge ref_clk or posedge sys_rst) begin
		if (sys_rst) begin
			istat_ff <= '0;
			irq_ff <= 1'b0;
		end else begin
			istat_ff <= evt | (istat_ff & ~iclr);
			irq_ff <= |(istat_ff & imask_ff);
		end
	end

	// Port drive
	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign {output_d, output_c, output_b, output_a} = out_ff;
	assign {output_d_oe, output_c_oe, output_b_oe, output_a_oe} = oe_ff;
	assign irq = irq_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_sw_force;
		@(posedge ref_clk) disable iff (sys_rst)
		(wr_asd0 && pwdata[`CPG_ASD0_FORCE]) |=> shutdown_force_bit_ff ##1 shut_ff;
	endproperty
	a_sw_force: assert property (p_sw_force) else $error("force write did not shut down");

	property p_hold_until_rise;
		@(posedge ref_clk) disable iff (sys_rst)
		(shut_ff && !rise_evt) |=> shut_ff;
	endproperty
	a_hold_until_rise: assert property (p_hold_until_rise) else $error("shutdown left early");

	property p_auto_clear;
		@(posedge ref_clk) disable iff (sys_rst)
		(auto_restart_enable_ff && shutdown_force_bit_ff && !src_active
			&& !(wr_asd0 && pwdata[`CPG_ASD0_FORCE])) |=> !shutdown_force_bit_ff;
	endproperty
	a_auto_clear: assert property (p_auto_clear) else $error("auto restart did not clear force");

	property p_ext_latch_reset;
		@(posedge ref_clk) disable iff (sys_rst)
		src_active |=> (shut_ff && !prim_ff && !comp_ff);
	endproperty
	a_ext_latch_reset: assert property (p_ext_latch_reset) else $error("latches not reset");

	property p_pin_source;
		@(posedge ref_clk) disable iff (sys_rst)
		(sel_ff[0] && !pin_in) || (sel_ff[3] && !logic_cell2_result) |=> shutdown_force_bit_ff;
	endproperty
	a_pin_source: assert property (p_pin_source) else $error("low source ignored");

	property p_clear_blocked;
		@(posedge ref_clk) disable iff (sys_rst)
		(src_active && wr_asd0 && !pwdata[`CPG_ASD0_FORCE]) |=> shutdown_force_bit_ff;
	endproperty
	a_clear_blocked: assert property (p_clear_blocked) else $error("force cleared under fault");

	property p_ac_low;
		@(posedge ref_clk) disable iff (sys_rst)
		(shut_now && override_level_pair_ac_ff == cpg_pkg::OVR_LOW)
			|=> (!output_a && output_a_oe && !output_c);
	endproperty
	a_ac_low: assert property (p_ac_low) else $error("A/C not forced low");

	property p_bd_tri;
		@(posedge ref_clk) disable iff (sys_rst)
		(shut_now && override_level_pair_bd_ff == cpg_pkg::OVR_TRI)
			|=> (!output_b_oe && !output_d_oe);
	endproperty
	a_bd_tri: assert property (p_bd_tri) else $error("B/D not released");

	property p_inact_pol;
		@(posedge ref_clk) disable iff (sys_rst)
		(shut_now && override_level_pair_ac_ff == cpg_pkg::OVR_INACT)
			|=> (output_a == $past(pol_ff[0]));
	endproperty
	a_inact_pol: assert property (p_inact_pol) else $error("inactive level ignores polarity");

	property p_high_no_pol;
		@(posedge ref_clk) disable iff (sys_rst)
		(shut_now && override_level_pair_bd_ff == cpg_pkg::OVR_HIGH) |=> (output_b && output_d);
	endproperty
	a_high_no_pol: assert property (p_high_no_pol) else $error("forced high inverted");

	property p_rise_gate;
		@(posedge ref_clk) disable iff (sys_rst)
		(rising_source0_enable_ff && !rising_source0_mode_ff && pin_in) |-> rise_evt;
	endproperty
	a_rise_gate: assert property (p_rise_gate) else $error("level rising event missed");

	property p_rise_off;
		@(posedge ref_clk) disable iff (sys_rst)
		!rising_source0_enable_ff |-> !rise_evt;
	endproperty
	a_rise_off: assert property (p_rise_off) else $error("disabled source made event");

	property p_prim_after_db;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(prim_ff) |-> $past(rise_done);
	endproperty
	a_prim_after_db: assert property (p_prim_after_db) else $error("primary skipped dead-band");

	property p_comp_after_db;
		@(posedge ref_clk) disable iff (sys_rst)
		$rose(comp_ff) |-> $past(fall_done);
	endproperty
	a_comp_after_db: assert property (p_comp_after_db) else $error("complement skipped dead-band");

	property p_db_upper_zero;
		@(posedge ref_clk) disable iff (sys_rst)
		(nxt_pready && !pwrite && (hit_dbr || hit_dbf)) |=> (prdata[31:6] == 26'h0000000);
	endproperty
	a_db_upper_zero: assert property (p_db_upper_zero) else $error("count upper bits not zero");

	property p_merge;
		@(posedge ref_clk) disable iff (sys_rst)
		(shutdown_force_bit_ff || src_active) |=> shut_ff;
	endproperty
	a_merge: assert property (p_merge) else $error("shutdown state not merged");
endmodule // cpg_top
`default_nettype wire

// ==== verif/cpg_stage_model.sv ====
// Power stage and fault detector model facing the generator pins and shutdown inputs
`timescale 1ns/10ps
`default_nettype none
module cpg_stage_model (
	input wire logic [3:0] fault_req,
	input wire logic pin_drive,
	input wire logic [3:0] gate_out,
	input wire logic [3:0] gate_oe,
	output logic pin_in,
	output logic comparator1_result,
	output logic comparator2_result,
	output logic logic_cell2_result,
	output logic [3:0] gate_level
);
	// Fault detectors pull their line low while a fault is requested
	assign pin_in = pin_drive & ~fault_req[0];
	assign comparator1_result = ~fault_req[1];
	assign comparator2_result = ~fault_req[2];
	assign logic_cell2_result = ~fault_req[3];
	// Gate drivers have pull-downs, so a released pin reads low
	assign gate_level = gate_out & gate_oe;
endmodule // cpg_stage_model
`default_nettype wire

// ==== verif/cpg_top_tb.sv ====
// Self-checking testbench of the complementary generator shutdown block
`timescale 1ns/10ps
`include "cpg_params.svh"
`default_nettype none
module cpg_top_tb;
	logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr, irq;
	logic pin_in, cmp1, cmp2, lc2, pin_drive, fall_event_in;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd_val;
	logic [3:0] fault_req, gout, goe, lvl;
	int fail_count, n_checks, d1, d2;
	cpg_top #(.CHAIN_DIV(2)) dut_u (.ref_clk(ref_clk), .sys_rst(sys_rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .comparator1_result(cmp1),
		.comparator2_result(cmp2), .logic_cell2_result(lc2), .fall_event_in(fall_event_in),
		.output_a(gout[0]), .output_a_oe(goe[0]), .output_b(gout[1]), .output_b_oe(goe[1]),
		.output_c(gout[2]), .output_c_oe(goe[2]), .output_d(gout[3]), .output_d_oe(goe[3]),
		.irq(irq));
	cpg_stage_model stage_u (.fault_req(fault_req), .pin_drive(pin_drive), .gate_out(gout),
		.gate_oe(goe), .pin_in(pin_in), .comparator1_result(cmp1), .comparator2_result(cmp2),
		.logic_cell2_result(lc2), .gate_level(lvl));
	// ------------------------------------------------------------
	// Clock, checks and verdict
	// ------------------------------------------------------------
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	// One APB transfer; waits for pready under a bounded count
	task xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		int k;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge ref_clk);
			k++;
		end while (pready !== 1'b1 && k < 50);
		if (k >= 50) fail_count++;
		r = pslverr === 1'b1 ? 32'hEEEE_EEEE : prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		xfer(a, 1'b1, d, rd_val);
	endtask
	task rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		xfer(a, 1'b0, 32'h0, rd_val);
		chk(rd_val & m, exp);
	endtask
	// Events on the rising source pin and on the falling input
	task fire(input bit rise);
		if (rise) pin_drive <= 1'b0;
		else fall_event_in <= 1'b1;
		@(posedge ref_clk);
		pin_drive <= 1'b1;
		fall_event_in <= 1'b0;
		@(posedge ref_clk);
	endtask
	// Cycles from an event until the watched pin rises
	task meas(input bit comp, output int n);
		fire(comp);
		repeat (100) @(posedge ref_clk);
		fire(!comp);
		n = 0;
		while (lvl[comp] !== 1'b1 && n < 300) begin
			@(posedge ref_clk);
			n++;
		end
	endtask
	function automatic logic lv(input logic [1:0] c, input logic inact);
		return c == 2'h2 ? 1'b1 : (c == 2'h0 ? inact : 1'b0);
	endfunction
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		give_verdict();
	end
	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		fail_count = 0;
		n_checks = 0;
		sys_rst = 1'b1;
		{psel, penable, pwrite, fall_event_in} = 4'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pin_drive = 1'b1;
		fault_req = 4'h0;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'b0;
		// Count registers keep six bits; unmapped place refused
		wr(`CPG_OFS_DBR, 32'hFF);
		rchk(`CPG_OFS_DBR, 32'hFFFF_FFFF, 32'h3F);
		wr(`CPG_OFS_DBF, 32'hFF);
		rchk(`CPG_OFS_DBF, 32'hFFFF_FFFF, 32'h3F);
		rchk(8'h30, 32'hFFFF_FFFF, 32'hEEEE_EEEE);
		// Software shutdown over every override code, polarity all set
		wr(`CPG_OFS_CTRL, 32'hF0);
		wr(`CPG_OFS_IMASK, 32'h3);
		for (int i = 0; i < 4; i++) begin
			wr(`CPG_OFS_ASD0, 32'h80 | ((3 - i) << 4) | (i << 2));
			repeat (2) @(posedge ref_clk);
			chk(lvl, {lv(2'(3 - i), 1'b0), lv(2'(i), 1'b1), lv(2'(3 - i), 1'b0), lv(2'(i), 1'b1)});
			chk(goe, {i != 0, i != 3, i != 0, i != 3});
		end
		rchk(`CPG_OFS_STAT, 32'h1, 32'h1);
		chk(irq, 1'b1);
		// Software clear holds overrides until a rising event
		wr(`CPG_OFS_ASD0, 32'h0C);
		repeat (3) @(posedge ref_clk);
		chk(goe, 4'hA);
		wr(`CPG_OFS_RSIM, 32'h1);
		wr(`CPG_OFS_RIS, 32'h1);
		rchk(`CPG_OFS_STAT, 32'h1, 32'h1);
		fire(1'b1);
		repeat (4) @(posedge ref_clk);
		rchk(`CPG_OFS_STAT, 32'h1, 32'h0);
		chk(goe, 4'hF);
		rchk(`CPG_OFS_ISTAT, 32'h3, 32'h3);
		wr(`CPG_OFS_ISTAT, 32'h3);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b0);
		// External sources with auto restart and level mode restart
		wr(`CPG_OFS_IMASK, 32'h0);
		wr(`CPG_OFS_RSIM, 32'h0);
		wr(`CPG_OFS_ASD1, 32'hF);
		wr(`CPG_OFS_ASD0, 32'h40);
		for (int i = 0; i < 4; i++) begin
			fault_req <= 4'h1 << i;
			repeat (3) @(posedge ref_clk);
			rchk(`CPG_OFS_STAT, 32'h1, 32'h1);
			wr(`CPG_OFS_ASD0, 32'h40);
			rchk(`CPG_OFS_ASD0, 32'h80, 32'h80);
			if (i == 0) chk(irq, 1'b0);
			fault_req <= 4'h0;
			repeat (6) @(posedge ref_clk);
			rchk(`CPG_OFS_ASD0, 32'h80, 32'h0);
			rchk(`CPG_OFS_STAT, 32'h1, 32'h0);
		end
		wr(`CPG_OFS_IMASK, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk(irq, 1'b1);
		wr(`CPG_OFS_ISTAT, 32'h3);
		rchk(`CPG_OFS_ISTAT, 32'h3, 32'h0);
		chk(irq, 1'b0);
		// A deselected source low does not shut down
		wr(`CPG_OFS_ASD1, 32'hE);
		fault_req <= 4'h1;
		repeat (3) @(posedge ref_clk);
		rchk(`CPG_OFS_STAT, 32'h1, 32'h0);
		fault_req <= 4'h0;
		// Dead-band delays scale with the count, in clock then chain ticks
		wr(`CPG_OFS_ASD0, 32'h0);
		wr(`CPG_OFS_RSIM, 32'h1);
		for (int m = 0; m < 2; m++) begin
			wr(`CPG_OFS_CTRL, m ? 32'h0C : 32'h0);
			for (int c = 0; c < 2; c++) begin
				wr(`CPG_OFS_DBR, 32'h3);
				wr(`CPG_OFS_DBF, 32'h3);
				meas(c, d1);
				wr(`CPG_OFS_DBR, 32'h7);
				wr(`CPG_OFS_DBF, 32'h7);
				meas(c, d2);
				if (m == 0) chk(d2 - d1, 4);
				else chk(d2 - d1 >= 7 && d2 - d1 <= 9, 1'b1);
			end
		end
		give_verdict();
	end
endmodule // cpg_top_tb
`default_nettype wire
